/* src/alarm_trim_pkg.sv */
// package: register map, field layout and reset values of the alarm and trim bank
package alarm_trim_pkg;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [9:0] IDX_SUMMARY = 10'h2C0;
  localparam logic [9:0] IDX_STATUS = 10'h2C1;
  localparam logic [9:0] IDX_MASK = 10'h2C2;
  localparam logic [9:0] IDX_LANE = 10'h2C4;
  localparam logic [9:0] IDX_TRIM0 = 10'h330;
  localparam logic [9:0] IDX_TRIM1 = 10'h332;
  localparam logic [9:0] IDX_TRIM2A = 10'h334;

  // alarm status / mask bit positions (same layout in both registers)
  localparam int BIT_BUFFER_ERROR = 5;
  localparam int BIT_SERIALIZER_LOCK = 4;
  localparam int BIT_LINK_STATE = 3;
  localparam int BIT_REALIGNMENT = 2;
  localparam int BIT_DIVIDER_MISMATCH = 0;
  localparam int BIT_SUMMARY = 0;

  // trim field position
  localparam int TRIM_LSB = 0;
  localparam int TRIM_MSB = 11;

  // reset values
  localparam logic [7:0] MASK_RESET = 8'h3F;
  localparam logic [7:0] STATUS_RESET = 8'h3F;
  localparam logic [7:0] LANE_RESET = 8'hFF;

  // htrans encoding of the bus
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_FETCH,
    BUS_READ_DONE
  } bus_phase_e;

endpackage

/* src/alarm_mask_and_offset_trim_regs.sv */
// alarm mask, alarm status, per-lane buffer error and offset trim register bank on AHB-Lite
//
// How it works
// - mask bit 5 set keeps buffer error status out of the summary alarm.
// - mask bit 4 set keeps serializer lock lost status out of the summary.
// - mask bit 3 set keeps link state status out of the summary.
// - mask bit 2 set keeps realignment status out of the summary.
// - mask bit 0 set keeps divider mismatch status out of the summary.
// - mask register resets to 0x3F, all alarms masked.
// - lane error on lane i sets per-lane buffer error bit i.
// - writing one to a per-lane bit clears it; zero leaves it.
// - a lane error still present re-sets its bit at once.
// - writing one to status bit 5 clears all eight per-lane bits.
// - per-lane buffer error register resets to 0xFF.
// - core 0 trim bits 11:0 drive core 0, default from fuses.
// - core 1 trim bits 11:0 drive core 1, default from fuses.
// - core 2 input A trim applies only while core 2 samples input A.
// - summary alarm is one while any unmasked alarm status bit (5, 4, 3, 2 or 0) is set.
// - buffer error status sets on any active lane error, clears on write one.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module alarm_mask_and_offset_trim_regs
  import alarm_trim_pkg::*;
#(
  parameter int LANES = 8,
  parameter int TRIM_W = 12
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // alarm sources, levels
  input wire logic [LANES-1:0] lane_buffer_error_i,
  input wire logic [LANES-1:0] lane_active_i,
  input wire logic serializer_lock_lost_i,
  input wire logic link_state_alarm_i,
  input wire logic realignment_i,
  input wire logic divider_mismatch_i,
  // fuse defaults for the trims, sampled while reset is high
  input wire logic [TRIM_W-1:0] fuse_core0_offset_i,
  input wire logic [TRIM_W-1:0] fuse_core1_offset_i,
  input wire logic [TRIM_W-1:0] fuse_core2_input_a_offset_i,
  input wire logic core2_samples_input_a_i,
  // to the converter cores
  output logic [TRIM_W-1:0] core0_offset_o,
  output logic [TRIM_W-1:0] core1_offset_o,
  output logic [TRIM_W-1:0] core2_offset_o,
  output logic irq_o
);

  // status bits that are real alarms; bits 7:6 and 1 are reserved storage only
  localparam logic [7:0] ALARM_BITS = 8'h3D;

  typedef struct packed {
    bus_phase_e phase;
    logic [9:0] index;
    logic mapped;
    logic [31:0] rdata;
    logic [7:0] alarm_mask_reg;
    logic [7:0] alarm_status_reg;
    logic [LANES-1:0] per_lane_buffer_error;
    logic [15:0] core0_offset_value;
    logic [15:0] core1_offset_value;
    logic [15:0] core2_input_a_offset_value;
    logic [TRIM_W-1:0] core2_out;
    logic irq;
  } state_s;

  state_s state;
  state_s next_state;

  logic take;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic [7:0] unmasked;
  logic summary;
  logic [LANES-1:0] lane_clr;
  logic wr_status;
  logic wr_lane;
  logic [31:0] read_mux;

  // an address phase is accepted for any selected, ready NONSEQ or SEQ transfer; word size only decides mapped
  assign take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

  // hardware set sources for the alarm status register
  always_comb begin
    status_set = 8'h00;
    status_set[BIT_BUFFER_ERROR] = |(lane_buffer_error_i & lane_active_i);
    status_set[BIT_SERIALIZER_LOCK] = serializer_lock_lost_i;
    status_set[BIT_LINK_STATE] = link_state_alarm_i;
    status_set[BIT_REALIGNMENT] = realignment_i;
    status_set[BIT_DIVIDER_MISMATCH] = divider_mismatch_i;
  end

  assign wr_status = (state.phase == BUS_WRITE) && state.mapped && (state.index == IDX_STATUS);
  assign wr_lane = (state.phase == BUS_WRITE) && state.mapped && (state.index == IDX_LANE);

  // write-one-to-clear on alarm bits only
  assign status_clr = wr_status ? (hwdata_i[7:0] & ALARM_BITS) : 8'h00;

  // per-lane clear: direct write-one, or all lanes from the status buffer error bit
  always_comb begin
    lane_clr = '0;
    if (wr_lane) begin
      lane_clr = hwdata_i[LANES-1:0];
    end
    if (status_clr[BIT_BUFFER_ERROR]) begin
      lane_clr = '1;
    end
  end

  // a set mask bit removes its status bit from the summary
  assign unmasked = state.alarm_status_reg & ~state.alarm_mask_reg & ALARM_BITS;
  // the bit-wise gate above covers positions 4, 3, 2 and 0 in the same way
  assign summary = |unmasked;

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (state.index)
      IDX_SUMMARY: read_mux[BIT_SUMMARY] = summary;
      IDX_STATUS: read_mux[7:0] = state.alarm_status_reg;
      IDX_MASK: read_mux[7:0] = state.alarm_mask_reg;
      IDX_LANE: read_mux[LANES-1:0] = state.per_lane_buffer_error;
      IDX_TRIM0: read_mux[15:0] = state.core0_offset_value;
      IDX_TRIM1: read_mux[15:0] = state.core1_offset_value;
      IDX_TRIM2A: read_mux[15:0] = state.core2_input_a_offset_value;
      default: read_mux = 32'h0000_0000;
    endcase
    if (!state.mapped) begin
      read_mux = 32'h0000_0000;
    end
  end

  always_comb begin
    next_state = state;

    // bus phase sequencing; reads take one wait state so read data come from a flop
    unique case (state.phase)
      BUS_IDLE: begin
        next_state.phase = BUS_IDLE;
      end
      BUS_WRITE: begin
        next_state.phase = BUS_IDLE;
      end
      BUS_READ_FETCH: begin
        next_state.rdata = read_mux;
        next_state.phase = BUS_READ_DONE;
      end
      BUS_READ_DONE: begin
        next_state.phase = BUS_IDLE;
      end
    endcase
    if (take && state.phase != BUS_READ_FETCH) begin
      next_state.phase = hwrite_i ? BUS_WRITE : BUS_READ_FETCH;
      next_state.index = haddr_i[11:2];
      next_state.mapped = (haddr_i[31:12] == 20'h00000) && (haddr_i[1:0] == 2'h0)
                          && (hsize_i == HSIZE_WORD);
    end

    // plain read/write storage
    if (state.phase == BUS_WRITE && state.mapped) begin
      unique case (state.index)
        IDX_MASK: next_state.alarm_mask_reg = hwdata_i[7:0];
        IDX_TRIM0: next_state.core0_offset_value = hwdata_i[15:0];
        IDX_TRIM1: next_state.core1_offset_value = hwdata_i[15:0];
        IDX_TRIM2A: next_state.core2_input_a_offset_value = hwdata_i[15:0];
        IDX_STATUS: begin
          // reserved status bits behave as plain storage
          next_state.alarm_status_reg = (state.alarm_status_reg & ALARM_BITS)
                                        | (hwdata_i[7:0] & ~ALARM_BITS);
        end
        default: next_state.alarm_mask_reg = state.alarm_mask_reg;
      endcase
    end

    // sticky alarms: set wins over a clear in the same cycle
    next_state.alarm_status_reg = (next_state.alarm_status_reg & ~status_clr) | status_set;
    next_state.per_lane_buffer_error = (state.per_lane_buffer_error & ~lane_clr)
                                       | lane_buffer_error_i;
    // a persisting lane error lands in the same update as its clear

    // trims reach the cores from flops
    next_state.core2_out = core2_samples_input_a_i
                           ? state.core2_input_a_offset_value[TRIM_MSB:TRIM_LSB]
                           : '0;
    next_state.irq = |((next_state.alarm_status_reg) & ~next_state.alarm_mask_reg & ALARM_BITS);

    // synchronous reset; trim defaults follow the fuses while reset is held
    if (reset_i) begin
      next_state.phase = BUS_IDLE;
      next_state.index = '0;
      next_state.mapped = 1'b0;
      next_state.rdata = 32'h0000_0000;
      next_state.alarm_mask_reg = MASK_RESET;
      next_state.alarm_status_reg = STATUS_RESET;
      next_state.per_lane_buffer_error = LANE_RESET[LANES-1:0];
      next_state.core0_offset_value = {4'h0, fuse_core0_offset_i};
      next_state.core1_offset_value = {4'h0, fuse_core1_offset_i};
      next_state.core2_input_a_offset_value = {4'h0, fuse_core2_input_a_offset_i};
      next_state.core2_out = '0;
      next_state.irq = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  // reserved trim bits 15:12 are stored but never reach a core; software keeps them zero
  assign core0_offset_o = state.core0_offset_value[TRIM_MSB:TRIM_LSB];
  assign core1_offset_o = state.core1_offset_value[TRIM_MSB:TRIM_LSB];
  assign core2_offset_o = state.core2_out;
  assign irq_o = state.irq;

  assign hreadyout_o = (state.phase != BUS_READ_FETCH);
  assign hresp_o = 1'b0;
  assign hrdata_o = state.rdata;

endmodule

`default_nettype wire

/* test/alarm_trim_chk.sv */
// checker: bus timing, trim and reset relations at the bank's ports
`timescale 1ns/1ps
`default_nettype none
module alarm_trim_chk
  import alarm_trim_pkg::*;
#(parameter int TRIM_W = 12) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hreadyout_o,
  input wire logic [TRIM_W-1:0] fuse_core0_offset_i,
  input wire logic [TRIM_W-1:0] fuse_core1_offset_i,
  input wire logic core2_samples_input_a_i,
  input wire logic [TRIM_W-1:0] core0_offset_o,
  input wire logic [TRIM_W-1:0] core1_offset_o,
  input wire logic [TRIM_W-1:0] core2_offset_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_take(logic w);
    hsel_i && hready_i && htrans_i[1] && hwrite_i == w;
  endsequence
  // the write lands at the edge that ends its data phase
  sequence s_wr_to(logic [9:0] idx);
    hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i == {20'h0, idx, 2'h0} ##1 hready_i;
  endsequence
  property p_read_wait; s_take(1'h0) |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_write_ready; s_take(1'h1) |=> hreadyout_o; endproperty
  a_write_ready: assert property (p_write_ready) else $error("write stalled");
  property p_trim0; s_wr_to(IDX_TRIM0) |=> core0_offset_o == $past(hwdata_i[TRIM_W-1:0]); endproperty
  a_trim0: assert property (p_trim0) else $error("core0 trim not applied");
  property p_trim1; s_wr_to(IDX_TRIM1) |=> core1_offset_o == $past(hwdata_i[TRIM_W-1:0]); endproperty
  a_trim1: assert property (p_trim1) else $error("core1 trim not applied");
  property p_core2_off; !core2_samples_input_a_i |=> core2_offset_o == '0; endproperty
  a_core2_off: assert property (p_core2_off) else $error("core2 trim off input a");
  property p_reset_irq; $fell(reset_i) |-> !irq_o; endproperty
  a_reset_irq: assert property (p_reset_irq) else $error("irq after reset");
  property p_fuse0; $fell(reset_i) |-> core0_offset_o == $past(fuse_core0_offset_i); endproperty
  a_fuse0: assert property (p_fuse0) else $error("core0 fuse default");
  property p_fuse1; $fell(reset_i) |-> core1_offset_o == $past(fuse_core1_offset_i); endproperty
  a_fuse1: assert property (p_fuse1) else $error("core1 fuse default");
endmodule
bind alarm_mask_and_offset_trim_regs alarm_trim_chk #(.TRIM_W(TRIM_W)) chk (.*);
`default_nettype wire

/* test/alarm_mask_and_offset_trim_regs_bench.sv */
// testbench: register table, alarm masking, lane errors and trims
`timescale 1ns/1ps
`default_nettype none
module alarm_mask_and_offset_trim_regs_bench;
  import alarm_trim_pkg::*;
  typedef struct packed {logic w; logic [9:0] i; logic [31:0] d;} row_s;
  localparam logic [11:0] F0 = 12'h5A5, F1 = 12'h3C3, F2 = 12'h7E1;
  logic clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0, core2_sel = 1'h1;
  logic [31:0] haddr = '0, hwdata = '0, rd;
  logic [1:0] htrans = '0;
  logic [7:0] lane_err = '0;
  logic [7:0] lane_act = 8'hFF;
  logic [5:0] src = '0;
  wire logic hready, hresp, irq;
  wire logic [31:0] hrdata;
  wire logic [11:0] off0, off1, off2;
  int mismatches = 0, total_checks = 0, cycles = 0;
  int bits [5] = '{0, 2, 3, 4, 5};
  row_s rows [19];
  always #20 clk = ~clk;
  alarm_mask_and_offset_trim_regs dut (.clk_i(clk), .reset_i(reset), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD),
    .hready_i(hready), .hwdata_i(hwdata), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .lane_buffer_error_i(lane_err), .lane_active_i(lane_act),
    .serializer_lock_lost_i(src[4]), .link_state_alarm_i(src[3]), .realignment_i(src[2]),
    .divider_mismatch_i(src[0]), .fuse_core0_offset_i(F0), .fuse_core1_offset_i(F1),
    .fuse_core2_input_a_offset_i(F2), .core2_samples_input_a_i(core2_sel),
    .core0_offset_o(off0), .core1_offset_o(off1), .core2_offset_o(off2), .irq_o(irq));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // called just after a rising edge; waits on hready, the watchdog bounds it
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  task automatic irq_is(input string name, input logic e);
    repeat (2) @(posedge clk);
    chk(name, 32'(irq), 32'(e));
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rows = '{'{1'h0, IDX_MASK, 32'h3F}, '{1'h0, IDX_SUMMARY, 32'h0}, '{1'h0, IDX_STATUS, 32'h3F},
      '{1'h0, IDX_LANE, 32'hFF}, '{1'h1, IDX_LANE, 32'h0F},
      '{1'h0, IDX_LANE, 32'hF0}, '{1'h1, IDX_STATUS, 32'h20}, '{1'h0, IDX_LANE, 32'h0},
      '{1'h0, IDX_STATUS, 32'h1D}, '{1'h0, IDX_TRIM2A, {20'h0, F2}},
      '{1'h0, IDX_TRIM0, {20'h0, F0}}, '{1'h1, IDX_TRIM0, 32'hABC}, '{1'h0, IDX_TRIM0, 32'hABC},
      '{1'h1, IDX_TRIM1, 32'h123}, '{1'h0, IDX_TRIM1, 32'h123}, '{1'h1, IDX_MASK, 32'h02},
      '{1'h0, IDX_MASK, 32'h02}, '{1'h0, IDX_SUMMARY, 32'h1}, '{1'h0, 10'h3FF, 32'h0}};
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    for (int k = 0; k < 19; k++) begin
      bus(rows[k].w, rows[k].i, rows[k].d);
      if (!rows[k].w) chk("row read", rd, rows[k].d);
    end
    chk("core0 out", 32'(off0), 32'hABC);
    chk("core1 out", 32'(off1), 32'h123);
    $display("register table done");
    core2_sel <= 1'h0;
    repeat (2) @(posedge clk);
    chk("core2 off", 32'(off2), 32'h0);
    core2_sel <= 1'h1;
    repeat (2) @(posedge clk);
    chk("core2 on", 32'(off2), 32'(F2));
    irq_is("irq reset status", 1'h1);
    bus(1'h1, IDX_STATUS, 32'h3F);
    irq_is("irq cleared", 1'h0);
    foreach (bits[j]) begin
      if (bits[j] == 5) lane_err <= 8'h08;
      else src[bits[j]] <= 1'h1;
      @(posedge clk);
      src <= '0;
      irq_is("irq raised", 1'h1);
      bus(1'h1, IDX_MASK, 32'h02 | (32'h1 << bits[j]));
      irq_is("irq masked", 1'h0);
      if (bits[j] == 5) begin
        bus(1'h0, IDX_LANE, '0);
        chk("lane set", rd, 32'h08);
        bus(1'h1, IDX_LANE, 32'h08);
        bus(1'h0, IDX_LANE, '0);
        chk("lane persists", rd, 32'h08);
        lane_err <= '0;
      end
      bus(1'h1, IDX_STATUS, 32'h1 << bits[j]);
      bus(1'h1, IDX_MASK, 32'h02);
    end
    bus(1'h0, IDX_LANE, '0);
    chk("lanes cleared", rd, 32'h0);
    lane_act <= 8'hF7;
    lane_err <= 8'h08;
    @(posedge clk);
    lane_err <= '0;
    irq_is("irq inactive lane", 1'h0);
    bus(1'h0, IDX_LANE, '0);
    chk("inactive lane", rd, 32'h08);
    bus(1'h1, IDX_LANE, 32'hFF);
    bus(1'h0, IDX_LANE, '0);
    chk("lane w1c", rd, 32'h0);
    lane_act <= 8'hFF;
    irq_is("irq quiet", 1'h0);
    $display("alarm tests done");
    reset <= 1'h1;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    bus(1'h0, IDX_TRIM0, '0);
    chk("trim0 after reset", rd, {20'h0, F0});
    bus(1'h0, IDX_MASK, '0);
    chk("mask after reset", rd, 32'h3F);
    bus(1'h0, IDX_LANE, '0);
    chk("lanes after reset", rd, 32'hFF);
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire
